// ==== src/tcp_pkg.sv ====
// constants, register map and carrier types of the cc port timing engine
// assumes a single 20 MHz clock; all times become cycle counts here
package tcp_pkg;
	// ----------------------------------------------------------------
	// clock and times
	// ----------------------------------------------------------------
	localparam int unsigned CLK_KHZ        = 20000;
	localparam int unsigned CLK_MHZ        = 20;
	localparam int unsigned ATTACH_STEP_MS = 5;
	localparam int unsigned DETACH_MS      = 15;
	localparam int unsigned TRYWAIT_MS     = 15;
	localparam int unsigned RPCHG_MS       = 15;
	localparam int unsigned SRCDISC_MS     = 15;
	localparam int unsigned RECOVERY_MS    = 50;
	localparam int unsigned TRY_MS         = 100;
	localparam int unsigned TRY_TMO_MS     = 800;
	localparam int unsigned TOG_STEP_MS    = 25;
	localparam int unsigned ENABLE_MS      = 50;
	localparam int unsigned SOFTRST_MS     = 50;
	localparam int unsigned WEAK_BATTERY_SINK_MODE_MS     = 15;
	localparam int unsigned VBUS_RISE_US   = 375;
	localparam int unsigned VBUS_FALL_MS   = 15;
	localparam int unsigned ATTACH_STEP_CYC = ATTACH_STEP_MS * CLK_KHZ;
	localparam int unsigned DETACH_CYC      = DETACH_MS * CLK_KHZ;
	localparam int unsigned TRYWAIT_CYC     = TRYWAIT_MS * CLK_KHZ;
	localparam int unsigned RPCHG_CYC       = RPCHG_MS * CLK_KHZ;
	localparam int unsigned SRCDISC_CYC     = SRCDISC_MS * CLK_KHZ;
	localparam int unsigned RECOVERY_CYC    = RECOVERY_MS * CLK_KHZ;
	localparam int unsigned TRY_CYC         = TRY_MS * CLK_KHZ;
	localparam int unsigned TRY_TMO_CYC     = TRY_TMO_MS * CLK_KHZ;
	localparam int unsigned TOG_STEP_CYC    = TOG_STEP_MS * CLK_KHZ;
	localparam int unsigned ENABLE_CYC      = ENABLE_MS * CLK_KHZ;
	localparam int unsigned SOFTRST_CYC     = SOFTRST_MS * CLK_KHZ;
	localparam int unsigned WEAK_BATTERY_SINK_MODE_CYC     = WEAK_BATTERY_SINK_MODE_MS * CLK_KHZ;
	localparam int unsigned VBUS_RISE_CYC   = VBUS_RISE_US * CLK_MHZ;
	localparam int unsigned VBUS_FALL_CYC   = VBUS_FALL_MS * CLK_KHZ;
	// ----------------------------------------------------------------
	// sink share of the toggle period, percent, per duty code
	// ----------------------------------------------------------------
	localparam logic [6:0] DUTY_PCT_00 = 7'd70;
	localparam logic [6:0] DUTY_PCT_01 = 7'd60;
	localparam logic [6:0] DUTY_PCT_10 = 7'd50;
	localparam logic [6:0] DUTY_PCT_11 = 7'd40;
	localparam logic [6:0] PCT_FULL    = 7'd100;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_CMD    = 8'h04;
	localparam logic [7:0]  REG_STATUS = 8'h08;
	localparam int unsigned CTRL_ATT   = 0;
	localparam int unsigned CTRL_DUTY  = 3;
	localparam int unsigned CTRL_PER   = 5;
	localparam int unsigned CTRL_WBS   = 7;
	localparam int unsigned CTRL_TOG   = 8;
	localparam int unsigned CMD_REC    = 0;
	localparam int unsigned CMD_SRST   = 1;
	localparam logic [8:0]  CTRL_RST   = 9'h103;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       attach;
		logic       detach;
		logic       reattach;
		logic       cc_open;
		logic [1:0] rp_level;
	} tcp_cc_in_t;
	typedef struct packed {
		logic       try_abandon;
		logic       try_done;
		logic       reg_ready;
		logic       weak_battery_low;
		logic       present_src;
		logic       in_try;
		logic       in_recovery;
		logic       vbus_valid;
		logic [1:0] rp_level;
		logic       src_detached;
		logic       reattached;
		logic       sink_detached;
		logic       attached;
	} tcp_status_t;
	typedef enum logic {TOG_SNK, TOG_SRC} tcp_tog_t;
endpackage

// ==== src/tcp_port_timing.sv ====
// cc port timing engine: debounces, dwell timers, drp toggle, ahb-lite registers
// assumes cc and vbus comparator levels already synchronous to hclk
`timescale 1ns/10ps
module tcp_debounce (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        cond,
	input  wire logic [31:0] limit,
	output logic             done
);
	import tcp_pkg::*;
	logic [31:0] cnt_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_r <= 32'h0;
		else if (!cond)
			cnt_r <= 32'h0;
		else if (cnt_r < limit)
			cnt_r <= cnt_r + 32'h1;
	end
	// a limit lowered mid-count must not let the counter run on and wrap
	assign done = cond && (cnt_r >= limit);

	chk_count_restart: assert property (@(posedge clk) disable iff (!rst_n)
		!cond |=> cnt_r == 32'h0) else $error("debounce count kept after lapse");
	chk_done_needs_run: assert property (@(posedge clk) disable iff (!rst_n)
		done && limit != 32'h0 |-> $past(cond) && $past(cnt_r) + 32'h1 >= limit)
		else $error("debounce done without full run");
endmodule

module tcp_port_timing #(
	parameter int unsigned ATT_STEP  = tcp_pkg::ATTACH_STEP_CYC,
	parameter int unsigned DET_CYC   = tcp_pkg::DETACH_CYC,
	parameter int unsigned TW_CYC    = tcp_pkg::TRYWAIT_CYC,
	parameter int unsigned RP_CYC    = tcp_pkg::RPCHG_CYC,
	parameter int unsigned SD_CYC    = tcp_pkg::SRCDISC_CYC,
	parameter int unsigned REC_CYC   = tcp_pkg::RECOVERY_CYC,
	parameter int unsigned TRY_CYC   = tcp_pkg::TRY_CYC,
	parameter int unsigned TMO_CYC   = tcp_pkg::TRY_TMO_CYC,
	parameter int unsigned TOG_STEP  = tcp_pkg::TOG_STEP_CYC,
	parameter int unsigned EN_CYC    = tcp_pkg::ENABLE_CYC,
	parameter int unsigned SRST_CYC  = tcp_pkg::SOFTRST_CYC,
	parameter int unsigned WB_CYC    = tcp_pkg::WEAK_BATTERY_SINK_MODE_CYC,
	parameter int unsigned VR_CYC    = tcp_pkg::VBUS_RISE_CYC,
	parameter int unsigned VF_CYC    = tcp_pkg::VBUS_FALL_CYC
) (
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire tcp_pkg::tcp_cc_in_t  cc,
	input  wire logic                 role_is_sink,
	input  wire logic                 role_is_source,
	input  wire logic                 in_trywait,
	input  wire logic                 role_change,
	input  wire logic                 try_start,
	input  wire logic                 try_vbus_wait,
	input  wire logic                 vbus_sense_input,
	input  wire logic                 vdd_below_weak,
	input  wire logic                 enable_n,
	input  wire logic                 pin_config_mode,
	input  wire logic                 addr_strap_pin_float,
	output tcp_pkg::tcp_status_t      status,
	output logic                      weak_battery_irq
);
	import tcp_pkg::*;

	// share product period * pct must stay inside 32 bits
	if (ATT_STEP == 0 || ATT_STEP > 32'h1000_0000 ||
		TOG_STEP < 10 || TOG_STEP > 32'h0080_0000)
		$error("tcp_port_timing: step parameters out of range");

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic [8:0]  ctrl_r;
	logic        wr_pend_r;
	logic [7:0]  wr_addr_r;
	logic        recovery_request;
	logic        soft_rst_req;
	logic        reg_ready;
	logic [31:0] status_word;
	logic        addr_ok;

	assign addr_ok   = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= addr_ok && hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (addr_ok && !hwrite) begin
			case (haddr[7:0])
				REG_CTRL:   hrdata <= {23'h0, ctrl_r};
				REG_STATUS: hrdata <= status_word;
				default:    hrdata <= 32'h0;
			endcase
		end
	end

	assign recovery_request = wr_pend_r && reg_ready && wr_addr_r == REG_CMD && hwdata[CMD_REC];
	assign soft_rst_req     = wr_pend_r && reg_ready && wr_addr_r == REG_CMD && hwdata[CMD_SRST];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ctrl_r <= CTRL_RST;
		else if (soft_rst_req)
			ctrl_r <= CTRL_RST;
		else if (wr_pend_r && reg_ready && wr_addr_r == REG_CTRL)
			ctrl_r <= hwdata[8:0];
	end

	// ----------------------------------------------------------------
	// access window after enable and soft reset
	// ----------------------------------------------------------------
	logic en_done;
	logic srst_busy_r;
	logic srst_done;

	tcp_debounce u_en (.clk(hclk), .rst_n(hresetn), .cond(!enable_n), .limit(EN_CYC),
		.done(en_done));
	tcp_debounce u_srst (.clk(hclk), .rst_n(hresetn), .cond(srst_busy_r), .limit(SRST_CYC),
		.done(srst_done));

	// busy until soft reset count ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			srst_busy_r <= 1'b0;
		else if (soft_rst_req)
			srst_busy_r <= 1'b1;
		else if (srst_done)
			srst_busy_r <= 1'b0;
	end
	assign reg_ready = en_done && !srst_busy_r;

	// ----------------------------------------------------------------
	// cc debounces
	// ----------------------------------------------------------------
	logic [31:0] att_limit;
	logic        att_done, det_done, tw_done, rp_done, sd_done;
	logic        attached_r, sink_det_r, reatt_r, src_det_r;
	logic [1:0]  rp_r;

	// attach time scales with the field
	assign att_limit = ATT_STEP * ({29'h0, ctrl_r[CTRL_ATT +: 3]} + 32'h1);
	tcp_debounce u_att (.clk(hclk), .rst_n(hresetn), .cond(cc.attach), .limit(att_limit),
		.done(att_done));
	tcp_debounce u_det (.clk(hclk), .rst_n(hresetn), .cond(cc.detach && role_is_sink),
		.limit(DET_CYC), .done(det_done));
	tcp_debounce u_tw (.clk(hclk), .rst_n(hresetn), .cond(cc.reattach && in_trywait),
		.limit(TW_CYC), .done(tw_done));
	tcp_debounce u_rp (.clk(hclk), .rst_n(hresetn), .cond(role_is_sink && cc.rp_level != rp_r),
		.limit(RP_CYC), .done(rp_done));
	tcp_debounce u_sd (.clk(hclk), .rst_n(hresetn), .cond(cc.cc_open && role_is_source),
		.limit(SD_CYC), .done(sd_done));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			attached_r <= 1'b0;
			sink_det_r <= 1'b0;
			reatt_r    <= 1'b0;
			src_det_r  <= 1'b0;
		end else begin
			sink_det_r <= det_done;
			reatt_r    <= tw_done;
			src_det_r  <= sd_done;
			if (det_done || sd_done || !cc.attach)
				attached_r <= 1'b0;
			else if (att_done)
				attached_r <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rp_r <= 2'b00;
		else if (rp_done)
			rp_r <= cc.rp_level;
	end

	// ----------------------------------------------------------------
	// recovery and try dwell timers
	// ----------------------------------------------------------------
	logic in_rec_r, rec_done, in_try_r, try_done, try_done_r, tmo_done, tmo_r, tmo_seen_r;

	tcp_debounce u_rec (.clk(hclk), .rst_n(hresetn), .cond(in_rec_r), .limit(REC_CYC),
		.done(rec_done));
	tcp_debounce u_try (.clk(hclk), .rst_n(hresetn), .cond(in_try_r), .limit(TRY_CYC),
		.done(try_done));
	// vbus still up while waiting on discharge
	tcp_debounce u_tmo (.clk(hclk), .rst_n(hresetn), .cond(try_vbus_wait && status.vbus_valid),
		.limit(TMO_CYC), .done(tmo_done));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			in_rec_r <= 1'b0;
		else if (recovery_request || role_change)
			in_rec_r <= 1'b1;
		else if (rec_done)
			in_rec_r <= 1'b0;
	end

	// try dwell, one pulse on expiry
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_try_r   <= 1'b0;
			try_done_r <= 1'b0;
		end else begin
			try_done_r <= try_done;
			if (try_start)
				in_try_r <= 1'b1;
			else if (try_done)
				in_try_r <= 1'b0;
		end
	end

	// abandon pulses once per wait, not every cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tmo_r      <= 1'b0;
			tmo_seen_r <= 1'b0;
		end else begin
			tmo_r      <= tmo_done && !tmo_seen_r;
			tmo_seen_r <= tmo_done;
		end
	end

	// ----------------------------------------------------------------
	// vbus valid and weak battery
	// ----------------------------------------------------------------
	logic vr_done, vf_done, vbus_r, wb_done, wb_low_r, wb_irq_r;

	tcp_debounce u_vr (.clk(hclk), .rst_n(hresetn), .cond(vbus_sense_input && !vbus_r),
		.limit(VR_CYC), .done(vr_done));
	tcp_debounce u_vf (.clk(hclk), .rst_n(hresetn), .cond(!vbus_sense_input && vbus_r),
		.limit(VF_CYC), .done(vf_done));
	tcp_debounce u_wb (.clk(hclk), .rst_n(hresetn),
		.cond(ctrl_r[CTRL_WBS] && vdd_below_weak != wb_low_r), .limit(WB_CYC), .done(wb_done));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			vbus_r <= 1'b0;
		else if (vr_done)
			vbus_r <= 1'b1;
		else if (vf_done)
			vbus_r <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wb_low_r <= 1'b0;
			wb_irq_r <= 1'b0;
		end else begin
			wb_irq_r <= wb_done;
			if (wb_done)
				wb_low_r <= !wb_low_r;
		end
	end
	assign weak_battery_irq = wb_irq_r;

	// ----------------------------------------------------------------
	// drp toggle
	// ----------------------------------------------------------------
	tcp_tog_t    tog_r;
	logic [31:0] tog_cnt_r, period, sink_len;
	logic [6:0]  pct;
	logic [1:0]  duty;
	logic        strap_seen_r, strap_float_r, tog_run;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			strap_seen_r  <= 1'b0;
			strap_float_r <= 1'b0;
		end else if (!strap_seen_r) begin
			strap_seen_r  <= 1'b1;
			strap_float_r <= pin_config_mode && addr_strap_pin_float;
		end
	end
	assign duty = strap_float_r ? 2'b00 : ctrl_r[CTRL_DUTY +: 2];

	always_comb begin
		case (duty)
			2'b00:   pct = DUTY_PCT_00;
			2'b01:   pct = DUTY_PCT_01;
			2'b10:   pct = DUTY_PCT_10;
			default: pct = DUTY_PCT_11;
		endcase
	end
	// period is sink plus source share
	assign period   = TOG_STEP * ({30'h0, ctrl_r[CTRL_PER +: 2]} + 32'h1);
	assign sink_len = (period * {25'h0, pct}) / {25'h0, PCT_FULL};
	assign tog_run  = ctrl_r[CTRL_TOG] && !attached_r && !in_rec_r && !srst_busy_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tog_r     <= TOG_SNK;
			tog_cnt_r <= 32'h0;
		end else if (!tog_run) begin
			tog_cnt_r <= 32'h0;
		end else begin
			tog_cnt_r <= tog_cnt_r + 32'h1;
			case (tog_r)
				TOG_SNK: if (tog_cnt_r + 32'h1 >= sink_len) begin
					tog_r     <= TOG_SRC;
					tog_cnt_r <= 32'h0;
				end
				TOG_SRC: if (tog_cnt_r + 32'h1 >= period - sink_len) begin
					tog_r     <= TOG_SNK;
					tog_cnt_r <= 32'h0;
				end
				default: tog_r <= TOG_SNK;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status
	// ----------------------------------------------------------------
	always_comb begin
		status.attached         = attached_r;
		status.sink_detached    = sink_det_r;
		status.reattached       = reatt_r;
		status.src_detached     = src_det_r;
		status.rp_level         = rp_r;
		status.vbus_valid       = vbus_r;
		status.in_recovery      = in_rec_r;
		status.in_try           = in_try_r;
		status.present_src      = tog_r == TOG_SRC;
		status.weak_battery_low = wb_low_r;
		status.reg_ready        = reg_ready;
		status.try_done         = try_done_r;
		status.try_abandon      = tmo_r;
	end
	assign status_word = {18'h0, status};

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_vbus_rise: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(vbus_r) |-> $past(vr_done)) else $error("vbus valid set without debounce");
	chk_vbus_fall: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(vbus_r) |-> $past(vf_done) && !$past(vbus_sense_input))
		else $error("vbus valid cleared without debounce");
	chk_recovery_entry: assert property (@(posedge hclk) disable iff (!hresetn)
		recovery_request |=> in_rec_r) else $error("recovery not entered");
	chk_weak_irq: assert property (@(posedge hclk) disable iff (!hresetn)
		weak_battery_irq |-> $changed(wb_low_r) && $past(ctrl_r[CTRL_WBS]))
		else $error("weak battery irq without crossing");
	chk_ready_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		enable_n |-> !reg_ready) else $error("registers ready while disabled");
	chk_soft_reset: assert property (@(posedge hclk) disable iff (!hresetn)
		soft_rst_req |=> ctrl_r == CTRL_RST && srst_busy_r && !reg_ready)
		else $error("soft reset did not restore defaults");
	chk_strap_duty: assert property (@(posedge hclk) disable iff (!hresetn)
		strap_float_r |-> pct == DUTY_PCT_00) else $error("strap duty not 70/30");
	chk_toggle_switch: assert property (@(posedge hclk) disable iff (!hresetn)
		tog_run && tog_r == TOG_SNK && tog_cnt_r + 32'h1 >= sink_len |=> tog_r == TOG_SRC)
		else $error("toggle switch late");
	chk_toggle_share: assert property (@(posedge hclk) disable iff (!hresetn)
		duty == 2'b10 |-> sink_len * 32'h2 == period) else $error("50/50 share wrong");
	chk_attach_set: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(attached_r) |-> $past(att_done)) else $error("attach without debounce");
	chk_try_leave: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(in_try_r) |-> $past(try_done)) else $error("try left early");
	chk_src_open: assert property (@(posedge hclk) disable iff (!hresetn)
		sd_done |=> !attached_r && src_det_r) else $error("source open not acted on");

	cov_attach: cover property (@(posedge hclk) disable iff (!hresetn) $rose(attached_r));
	cov_toggle: cover property (@(posedge hclk) disable iff (!hresetn) $rose(status.present_src));
	cov_recovery: cover property (@(posedge hclk) disable iff (!hresetn) $fell(in_rec_r));
	cov_weak_irq: cover property (@(posedge hclk) disable iff (!hresetn) weak_battery_irq);
endmodule

// ==== verif/tcp_cc_partner.sv ====
// port partner model facing the cc comparators and the vbus sense input
// assumes the bench steers plug, advertised level and vbus from hclk edges
`timescale 1ns/10ps
module tcp_cc_partner (
	input  wire logic          hclk,
	input  wire logic          plug,
	input  wire logic [1:0]    rp,
	input  wire logic          vbus_on,
	output tcp_pkg::tcp_cc_in_t cc,
	output logic               vbus_sense_input
);
	import tcp_pkg::*;
	// ---------------------------------------------------------------
	// line levels
	// ---------------------------------------------------------------
	// unplugged cc falls to the pull-down, so no stale level survives
	always_ff @(posedge hclk) begin
		cc <= {plug, !plug, plug, !plug, plug ? rp : 2'h0};
		vbus_sense_input <= vbus_on;
	end
endmodule

// ==== verif/tcp_port_timing_test.sv ====
// bench for the cc port timing engine, register access over ahb-lite
// assumes small timer parameters and a zero-wait slave
`timescale 1ns/10ps
module tcp_port_timing_test;
	import tcp_pkg::*;
	localparam int unsigned ATT = 4, DET = 8, TW = 8, RP = 8, SD = 8, REC = 10;
	localparam int unsigned TRY = 12, TMO = 16, TS = 10, EN = 6, SR = 6, WB = 8;
	localparam int unsigned VR = 5, VF = 8;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
	logic [1:0]  htrans = 0, rp = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic        sink = 0, src = 0, tw = 0, rc = 0, ts = 0, tvw = 0, vdd = 0;
	logic        en_n = 1, pcm = 0, flt = 0, plug = 0, vb = 0, vsense, irq;
	tcp_cc_in_t  cc;
	tcp_status_t status;
	int          failures = 0, check_count = 0, n, irqs = 0;
	always #25 hclk = ~hclk;
	always @(negedge hclk) if (irq === 1'b1) irqs++;
	tcp_cc_partner u_cc (.hclk, .plug, .rp, .vbus_on(vb), .cc, .vbus_sense_input(vsense));
	tcp_port_timing #(
		.ATT_STEP(ATT), .DET_CYC(DET), .TW_CYC(TW), .RP_CYC(RP), .SD_CYC(SD),
		.REC_CYC(REC), .TRY_CYC(TRY), .TMO_CYC(TMO), .TOG_STEP(TS), .EN_CYC(EN),
		.SRST_CYC(SR), .WB_CYC(WB), .VR_CYC(VR), .VF_CYC(VF)
	) u_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .cc, .role_is_sink(sink),
		.role_is_source(src), .in_trywait(tw), .role_change(rc), .try_start(ts),
		.try_vbus_wait(tvw), .vbus_sense_input(vsense), .vdd_below_weak(vdd),
		.enable_n(en_n), .pin_config_mode(pcm), .addr_strap_pin_float(flt),
		.status, .weak_battery_irq(irq)
	);
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one single word transfer; read data taken at the data-phase edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
		cmp(32'(hresp), 32'h0);
	endtask
	// edges until a status bit takes a value, compared against a window
	task automatic span(input int b, input logic v, input int lo, input int hi);
		n = 0;
		#1;
		while (status[b] !== v && n < 3000) begin
			@(posedge hclk);
			#1;
			n++;
		end
		cmp(32'(n >= lo && n <= hi), 32'h1);
	endtask
	task automatic tog(input logic [1:0] d, input logic [1:0] p, input int s);
		int per;
		per = TS * (int'(p) + 1);
		bus(1'h1, REG_CTRL, 32'h100 | (32'(d) << CTRL_DUTY) | (32'(p) << CTRL_PER));
		span(9, 1'b1, 0, 2000);
		span(9, 1'b0, 0, 2000);
		span(9, 1'b1, per * s / 100, per * s / 100);
		span(9, 1'b0, per - per * s / 100, per - per * s / 100);
	endtask
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		#(50 * 20000);
		failures++;
		close_out;
	end
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		bus(1'h1, REG_CTRL, 32'h0);
		@(posedge hclk) en_n <= 1'h0;
		span(11, 1'b1, EN, EN + 2);
		bus(1'h0, REG_CTRL, 32'h0);
		cmp(q, 32'h103);
		bus(1'h0, 8'h0C, 32'h0);
		cmp(q, 32'h0);
		$display("access test done");
		for (int d = 0; d < 4; d++)
			tog(d[1:0], 2'h0, 70 - 10 * d);
		tog(2'h0, 2'h1, 70);
		tog(2'h1, 2'h3, 60);
		$display("toggle test done");
		// attach sel 1 doubles the step; the short touch must not count
		bus(1'h1, REG_CTRL, 32'h101);
		@(posedge hclk) plug <= 1'h1;
		repeat (5) @(posedge hclk);
		plug <= 1'h0;
		repeat (4) @(posedge hclk);
		plug <= 1'h1;
		span(0, 1'b1, 2 * ATT, 2 * ATT + 3);
		@(posedge hclk) sink <= 1'h1;
		rp <= 2'h2;
		span(5, 1'b1, RP, RP + 3);
		@(posedge hclk) plug <= 1'h0;
		span(1, 1'b1, DET, DET + 3);
		@(posedge hclk) sink <= 1'h0;
		src <= 1'h1;
		plug <= 1'h1;
		span(0, 1'b1, 0, 2000);
		@(posedge hclk) plug <= 1'h0;
		span(3, 1'b1, SD, SD + 3);
		@(posedge hclk) tw <= 1'h1;
		plug <= 1'h1;
		span(2, 1'b1, TW, TW + 3);
		$display("cc debounce test done");
		for (int i = 0; i < 2; i++) begin
			if (i == 0)
				bus(1'h1, REG_CMD, 32'h1);
			else begin
				@(posedge hclk) rc <= 1'h1;
				@(posedge hclk) rc <= 1'h0;
			end
			span(7, 1'b1, 0, 3);
			span(7, 1'b0, REC, REC + 1);
		end
		$display("recovery test done");
		@(posedge hclk) vb <= 1'h1;
		span(6, 1'b1, VR, VR + 3);
		@(posedge hclk) ts <= 1'h1;
		@(posedge hclk) ts <= 1'h0;
		span(8, 1'b1, 0, 3);
		span(12, 1'b1, TRY - 1, TRY + 3);
		@(posedge hclk) tvw <= 1'h1;
		span(13, 1'b1, TMO, TMO + 3);
		@(posedge hclk) vb <= 1'h0;
		tvw <= 1'h0;
		span(6, 1'b0, VF, VF + 3);
		$display("vbus and try test done");
		bus(1'h1, REG_CTRL, 32'h180);
		@(posedge hclk) vdd <= 1'h1;
		span(10, 1'b1, WB, WB + 3);
		@(posedge hclk) vdd <= 1'h0;
		span(10, 1'b0, WB, WB + 3);
		// let the counter see the last pulse at its falling edge
		@(posedge hclk);
		cmp(irqs, 32'h2);
		bus(1'h1, REG_CMD, 32'h2);
		span(11, 1'b0, 0, 3);
		span(11, 1'b1, SR, SR + 2);
		bus(1'h0, REG_CTRL, 32'h0);
		cmp(q, 32'h103);
		bus(1'h0, REG_STATUS, 32'h0);
		cmp(q & 32'h800, 32'h800);
		$display("battery and soft reset test done");
		@(posedge hclk) hresetn <= 1'h0;
		pcm <= 1'h1;
		flt <= 1'h1;
		plug <= 1'h0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		span(11, 1'b1, 0, 2000);
		tog(2'h3, 2'h0, 70);
		$display("strap test done");
		close_out;
	end
endmodule
